// ---- hdl/ctic_timer.sv ----
// Timing generator and 8-bit interval timer/event counter with APB access.
//
// Contract
// - State counter divides the oscillator by three.
// - Each machine cycle is exactly five consecutive states.
// - Cycle counter divides states by five to make the cycle strobe.
// - Cycle strobe is driven out continuously, never gated.
// - Eight-bit count register counts prescaled ticks or external events.
// - Software presets and samples the count register.
// - Only the load instruction presets the count; reset keeps it.
// - Reset or halt stops counting until a start instruction.
// - Running counter wraps from maximum to zero and continues.
// - Wrap to zero sets the overflow flag and a timer request.
// - Overflow flag is cleared by the jump test or by reset.
// - Timer request is latched and ORed with the host request.
// - Timer interrupt enable is separate from the host enable.
// - Enabled overflow forces a call to location 7.
// - Simultaneous requests serve the host source first at location 3.
// - Losing timer request stays pending until after host service return.
// - Entering the timer service clears the pending timer latch.
// - Timer mode gives delays of 80 us to 20.48 ms.
// - Timer input is the cycle clock divided by thirty-two.
// - Event mode counts high-to-low transitions of the event pin.
// - Event pin is sampled once per cycle; low after high counts.
// - Starting event mode keeps the existing count.
//
// The register offsets and the APB slave port were left to the implementer.
module ctic_timer
	import ctic_pkg::*;
(
	input  wire logic        CLOCK,      // Oscillator clock
	input  wire logic        ARST_N,     // Asynchronous reset, active low
	input  wire logic        PSEL,       // APB select
	input  wire logic        PENABLE,    // APB access phase
	input  wire logic        PWRITE,     // APB write
	input  wire logic [7:0]  PADDR,      // APB byte address
	input  wire logic [31:0] PWDATA,     // APB write data
	output logic             PREADY,     // APB ready
	output logic             PSLVERR,    // APB error on unmapped address
	output logic      [31:0] PRDATA,     // APB read data
	input  wire logic        EVENT_PIN,  // External event input
	input  wire logic        HOST_REQ,   // Host input buffer full request
	output logic             CYCLE_SYNC, // Machine cycle strobe
	output logic             IRQ_OUT,    // Combined interrupt request
	output logic             CALL_VALID, // Forced call pulse
	output logic       [9:0] CALL_VEC    // Forced call vector
);

	// ------------------------------------------------------------
	// Timing chain
	// ------------------------------------------------------------
	logic [2:0] state_cnt;
	logic [2:0] cyc_cnt;
	logic [4:0] pre_cnt;
	logic       state_end;
	logic       cyc_end;
	logic       tick;

	assign state_end = (state_cnt == STATE_LAST);
	assign cyc_end   = state_end && (cyc_cnt == CYC_LAST);
	assign tick      = cyc_end && (pre_cnt == PRE_LAST);

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_cnt <= 3'h0;
		end else if (state_end) begin
			state_cnt <= 3'h0;
		end else begin
			state_cnt <= state_cnt + 3'h1;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			cyc_cnt <= 3'h0;
		end else if (cyc_end) begin
			cyc_cnt <= 3'h0;
		end else if (state_end) begin
			cyc_cnt <= cyc_cnt + 3'h1;
		end
	end

	// The strobe is high for the first state of every cycle; it is a
	// register so the pin never glitches.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			CYCLE_SYNC <= 1'b0;
		end else begin
			CYCLE_SYNC <= cyc_end || (cyc_cnt == 3'h0 && !state_end);
		end
	end

	// The prescaler runs free so a timer start lands on any phase of it.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			pre_cnt <= 5'h0;
		end else if (cyc_end) begin
			pre_cnt <= pre_cnt + 5'h1;
		end
	end

	// ------------------------------------------------------------
	// Event pin synchroniser and sampler
	// ------------------------------------------------------------
	logic ev_meta;
	logic ev_sync;
	logic ev_seen_high;
	logic ev_pulse;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ev_meta <= 1'b0;
			ev_sync <= 1'b0;
		end else begin
			ev_meta <= EVENT_PIN;
			ev_sync <= ev_meta;
		end
	end

	assign ev_pulse = cyc_end && ev_seen_high && !ev_sync;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ev_seen_high <= 1'b0;
		end else if (cyc_end) begin
			ev_seen_high <= ev_sync;
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	logic        acc;
	logic        wr;
	logic        mapped;
	logic [31:0] next_rdata;

	assign acc     = PSEL && PENABLE;
	assign wr      = acc && PWRITE;
	assign PREADY  = 1'b1;
	assign mapped  = (PADDR == ADDR_CMD) || (PADDR == ADDR_COUNT) ||
			(PADDR == ADDR_STATUS) || (PADDR == ADDR_JUMP_TEST);
	assign PSLVERR = acc && !mapped;

	logic cmd_wr;
	logic start_tmr;
	logic start_evt;
	logic halt;
	logic jump_test_rd;

	assign cmd_wr    = wr && (PADDR == ADDR_CMD);
	assign start_tmr = cmd_wr && PWDATA[CMD_START_TMR];
	assign start_evt = cmd_wr && PWDATA[CMD_START_EVT];
	assign halt      = cmd_wr && PWDATA[CMD_HALT];
	assign jump_test_rd = acc && !PWRITE && (PADDR == ADDR_JUMP_TEST);

	// ------------------------------------------------------------
	// Mode and count
	// ------------------------------------------------------------
	ctic_mode_t mode;
	logic [7:0] count;
	logic       inc;
	logic       wrap;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode <= CTIC_STOPPED;
		end else if (halt) begin
			mode <= CTIC_STOPPED;
		end else if (start_evt) begin
			mode <= CTIC_EVENT;
		end else if (start_tmr) begin
			mode <= CTIC_TIMER;
		end
	end

	always_comb begin
		case (mode)
			CTIC_TIMER: inc = tick;
			CTIC_EVENT: inc = ev_pulse;
			CTIC_STOPPED: inc = 1'b0;
			default: inc = 1'b0;
		endcase
	end

	assign wrap = inc && (count == COUNT_MAX);

	// No reset branch: the count survives reset.
	always_ff @(posedge CLOCK) begin
		if (wr && PADDR == ADDR_COUNT) begin
			count <= PWDATA[7:0];
		end else if (inc) begin
			count <= count + 8'h01;
		end
	end

	// Marks a count loaded since reset, so hold checks never see an
	// unloaded register.
	logic count_set;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			count_set <= 1'b0;
		end else if (wr && PADDR == ADDR_COUNT) begin
			count_set <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Overflow flag and interrupts
	// ------------------------------------------------------------
	logic overflow_flag;
	logic tmr_pend;
	logic tmr_en;
	logic host_en;
	logic in_service;
	logic host_meta;
	logic host_sync;
	logic take_host;
	logic take_tmr;
	logic ret;

	assign ret = cmd_wr && PWDATA[CMD_RETURN];

	// A wrap wins over the jump test, and the test clears only a flag that
	// it reported, so a wrap after the setup edge is never lost.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			overflow_flag <= 1'b0;
		end else if (wrap) begin
			overflow_flag <= 1'b1;
		end else if (jump_test_rd && PRDATA[0]) begin
			overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			host_meta <= 1'b0;
			host_sync <= 1'b0;
		end else begin
			host_meta <= HOST_REQ;
			host_sync <= host_meta;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			tmr_en  <= 1'b0;
			host_en <= 1'b0;
		end else if (cmd_wr) begin
			if (PWDATA[CMD_IRQ_ON]) tmr_en <= 1'b1;
			else if (PWDATA[CMD_IRQ_OFF]) tmr_en <= 1'b0;
			if (PWDATA[CMD_HOST_ON]) host_en <= 1'b1;
			else if (PWDATA[CMD_HOST_OFF]) host_en <= 1'b0;
		end
	end

	assign take_host = !in_service && host_en && host_sync;
	assign take_tmr  = !in_service && !take_host && tmr_en && tmr_pend;

	// A new wrap on the entry cycle wins over the clear.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			tmr_pend <= 1'b0;
		end else if (wrap) begin
			tmr_pend <= 1'b1;
		end else if (take_tmr) begin
			tmr_pend <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			in_service <= 1'b0;
		end else if (take_host || take_tmr) begin
			in_service <= 1'b1;
		end else if (ret) begin
			in_service <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			CALL_VALID <= 1'b0;
			CALL_VEC   <= 10'h000;
		end else begin
			CALL_VALID <= take_host || take_tmr;
			CALL_VEC   <= take_host ? VEC_HOST : VEC_TIMER;
		end
	end

	assign IRQ_OUT = (tmr_en && tmr_pend) || (host_en && host_sync);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0;
		case (PADDR)
			ADDR_COUNT: next_rdata = {24'h0, count};
			ADDR_STATUS: next_rdata = {25'h0, in_service, host_en,
					tmr_en, tmr_pend, overflow_flag, mode};
			ADDR_JUMP_TEST: next_rdata = {31'h0, overflow_flag};
			default: next_rdata = 32'h0;
		endcase
	end

	// Read data is captured in the setup phase, so the access phase still
	// needs no wait state.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			PRDATA <= 32'h0;
		end else if (PSEL && !PENABLE) begin
			PRDATA <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking assert_cb @(posedge CLOCK);
	endclocking
	default disable iff (!ARST_N);

	sequence wrap_s;
		wrap;
	endsequence

	state_div_a: assert property (
		state_end |=> !state_end [*2] ##1 state_end)
		else $error("state period is not three");

	cycle_div_a: assert property (
		cyc_end |=> !cyc_end [*8] ##0 1'b1)
		else $error("cycle ended too soon");

	cycle_five_a: assert property (
		cyc_end |-> ##15 cyc_end)
		else $error("cycle is not five states");

	sync_out_a: assert property (
		cyc_end |=> CYCLE_SYNC)
		else $error("cycle strobe missing");

	stop_hold_a: assert property (
		(count_set && mode == CTIC_STOPPED &&
		!(wr && PADDR == ADDR_COUNT))
		|=> count == $past(count))
		else $error("count moved while stopped");

	wrap_zero_a: assert property (
		wrap_s and !(wr && PADDR == ADDR_COUNT)
		|=> count == COUNT_ZERO && overflow_flag)
		else $error("wrap did not reach zero with flag");

	wrap_pend_a: assert property (
		wrap_s |=> tmr_pend)
		else $error("wrap did not latch request");

	jump_clear_a: assert property (
		jump_test_rd && PRDATA[0] && !wrap |=> !overflow_flag)
		else $error("jump test did not clear flag");

	host_first_a: assert property (
		take_host && tmr_en && tmr_pend |=> CALL_VEC == VEC_HOST
		&& tmr_pend)
		else $error("host not served first");

	tmr_call_a: assert property (
		take_tmr |=> CALL_VALID && CALL_VEC == VEC_TIMER)
		else $error("timer call wrong");

	tmr_entry_a: assert property (
		take_tmr && !wrap |=> !tmr_pend)
		else $error("entry did not clear pending");

	event_keep_a: assert property (
		count_set && start_evt && !inc
		|=> count == $past(count))
		else $error("event start altered count");

	halt_stop_a: assert property (
		halt |=> mode == CTIC_STOPPED)
		else $error("halt did not stop the counter");

	flag_keep_a: assert property (
		jump_test_rd && !PRDATA[0] && overflow_flag |=> overflow_flag)
		else $error("jump test lost an unreported flag");

	pend_hold_a: assert property (
		tmr_pend && !take_tmr |=> tmr_pend)
		else $error("pending timer request was lost");

endmodule

// ---- hdl/ctic_pkg.sv ----
// Package of constants and carrier types for the cycle timing and interval counter.
package ctic_pkg;

	// ------------------------------------------------------------
	// Timing chain
	// ------------------------------------------------------------
	localparam int unsigned OSC_PER_STATE   = 3;
	localparam int unsigned STATES_PER_CYC  = 5;
	localparam int unsigned PRESCALE_DIV    = 32;
	localparam int unsigned CLK_PERIOD_NS   = 10;
	// Shortest and longest programmed delay at the nominal 6 MHz oscillator.
	localparam int unsigned MIN_DELAY_NS    = 80000;
	localparam int unsigned MAX_DELAY_NS    = 20480000;
	localparam int unsigned TICKS_FULL      = 256;

	localparam logic [2:0] STATE_LAST = 3'h2;
	localparam logic [2:0] CYC_LAST   = 3'h4;
	localparam logic [4:0] PRE_LAST   = 5'h1F;
	localparam logic [7:0] COUNT_MAX  = 8'hFF;
	localparam logic [7:0] COUNT_ZERO = 8'h00;

	// ------------------------------------------------------------
	// Interrupt vectors
	// ------------------------------------------------------------
	localparam logic [9:0] VEC_HOST  = 10'h003;
	localparam logic [9:0] VEC_TIMER = 10'h007;

	// ------------------------------------------------------------
	// APB register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD    = 8'h00;
	localparam logic [7:0] ADDR_COUNT  = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_JUMP_TEST = 8'h0C;

	// Command register bit positions (write one to issue the instruction).
	localparam int unsigned CMD_START_TMR = 0;
	localparam int unsigned CMD_START_EVT = 1;
	localparam int unsigned CMD_HALT      = 2;
	localparam int unsigned CMD_IRQ_ON    = 3;
	localparam int unsigned CMD_IRQ_OFF   = 4;
	localparam int unsigned CMD_HOST_ON   = 5;
	localparam int unsigned CMD_HOST_OFF  = 6;
	localparam int unsigned CMD_RETURN    = 7;

	typedef enum logic [1:0] {
		CTIC_STOPPED,
		CTIC_TIMER,
		CTIC_EVENT
	} ctic_mode_t;

	typedef struct packed {
		logic       valid;
		logic [9:0] vector;
	} ctic_call_t;

endpackage

// ---- verification/ctic_core_model.sv ----
// APB master model of the processor core that issues timer instructions.
module ctic_core_model (
	input  wire logic        clk,     // Oscillator clock
	input  wire logic        pready,  // Slave ready
	input  wire logic        pslverr, // Slave error
	input  wire logic [31:0] prdata,  // Slave read data
	output logic             psel,    // Select
	output logic             penable, // Access phase
	output logic             pwrite,  // Direction
	output logic      [7:0]  paddr,   // Byte address
	output logic      [31:0] pwdata,  // Write data
	output logic             stuck    // Slave never answered
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stuck = 1'h0;
	end

	// ----
	// One transfer: setup, then access held until ready.
	// ----
	task automatic xfer(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'h1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		if (n >= 16)
			stuck = 1'h1;
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule

// ---- verification/cycle_timing_and_interval_counter_tb_top.sv ----
// Self-checking testbench of the cycle timing and interval counter.
module cycle_timing_and_interval_counter_tb_top;
	import ctic_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        event_pin;
	logic        host_req;
	logic        cycle_sync;
	logic        irq_out;
	logic        call_valid;
	logic [9:0]  call_vec;
	logic        stuck;
	logic [9:0]  last_vec;
	logic [31:0] q;
	logic        err;
	int          calls;
	int          cyc;
	int          t0;
	int          n;
	int          miscompares;
	int          checks_done;

	ctic_timer i_dut (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
		.EVENT_PIN(event_pin), .HOST_REQ(host_req), .CYCLE_SYNC(cycle_sync),
		.IRQ_OUT(irq_out), .CALL_VALID(call_valid), .CALL_VEC(call_vec));

	ctic_core_model i_core (.clk(clock), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .stuck(stuck));

	always #5 clock = ~clock;

	// Forced calls are single-cycle pulses, so they are logged here.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (call_valid === 1'h1) begin
			calls <= calls + 1;
			last_vec <= call_vec;
		end
	end

	// ----
	// Tasks
	// ----
	task automatic give_verdict();
		if (stuck === 1'h1)
			miscompares++;
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_core.xfer(1'h1, a, d, q, err);
	endtask

	task automatic rd(input logic [7:0] a);
		i_core.xfer(1'h0, a, 32'h0, q, err);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		rd(a);
		chk(nm, e, q);
	endtask

	task automatic bail(input int lim);
		if (n >= lim) begin
			miscompares++;
			give_verdict();
		end
	endtask

	task automatic wait_sync(input logic lvl);
		n = 0;
		while (cycle_sync !== lvl && n < 40) begin
			@(posedge clock);
			n++;
		end
		bail(40);
	endtask

	task automatic wait_change(input logic [7:0] old);
		n = 0;
		rd(ADDR_COUNT);
		while (q[7:0] === old && n < 400) begin
			rd(ADDR_COUNT);
			n++;
		end
		bail(400);
	endtask

	task automatic wait_call(input int k);
		n = 0;
		while (calls < k && n < 2000) begin
			@(posedge clock);
			n++;
		end
		bail(2000);
	endtask

	task automatic do_reset();
		arst_n <= 1'h0;
		repeat (6) @(posedge clock);
		arst_n <= 1'h1;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		clock = 1'h0;
		arst_n = 1'h0;
		event_pin = 1'h0;
		host_req = 1'h0;
		cyc = 0;
		calls = 0;
		miscompares = 0;
		checks_done = 0;
		do_reset();
		rdchk("status", ADDR_STATUS, 32'h0);
		wait_sync(1'h0);
		wait_sync(1'h1);
		t0 = cyc;
		wait_sync(1'h0);
		chk("sync_high", 32'h3, 32'(cyc - t0));
		wait_sync(1'h1);
		chk("sync_period", 32'hF, 32'(cyc - t0));
		wr(ADDR_COUNT, 32'h5A);
		rdchk("count", ADDR_COUNT, 32'h5A);
		rd(8'h10);
		chk("slverr", 32'h1, {31'h0, err});
		wr(ADDR_CMD, 32'h1 << CMD_START_TMR);
		do_reset();
		rdchk("count", ADDR_COUNT, 32'h5A);
		rdchk("status", ADDR_STATUS, 32'h0);
		wr(ADDR_COUNT, 32'hFE);
		wr(ADDR_CMD, 32'h1 << CMD_START_TMR);
		wait_change(8'hFE);
		t0 = cyc;
		wait_change(8'hFF);
		chk("tick", PRESCALE_DIV * STATES_PER_CYC * OSC_PER_STATE,
			32'(cyc - t0));
		chk("wrap", 32'h0, q);
		rdchk("jump_test", ADDR_JUMP_TEST, 32'h1);
		rdchk("jump_test", ADDR_JUMP_TEST, 32'h0);
		rdchk("status", ADDR_STATUS, 32'h9);
		wr(ADDR_CMD, 32'h1 << CMD_HALT);
		rd(ADDR_COUNT);
		t0 = int'(q);
		repeat (600) @(posedge clock);
		rdchk("halted", ADDR_COUNT, 32'(t0));
		// Timer request pending and host request raised, both disabled.
		host_req <= 1'h1;
		repeat (4) @(posedge clock);
		chk("irq_off", 32'h0, {31'h0, irq_out});
		wr(ADDR_CMD, (32'h1 << CMD_IRQ_ON) | (32'h1 << CMD_HOST_ON));
		wait_call(1);
		chk("vec_host", {22'h0, VEC_HOST}, {22'h0, last_vec});
		host_req <= 1'h0;
		repeat (4) @(posedge clock);
		rdchk("status", ADDR_STATUS, 32'h78);
		chk("irq_on", 32'h1, {31'h0, irq_out});
		wr(ADDR_CMD, 32'h1 << CMD_RETURN);
		wait_call(2);
		chk("vec_tmr", {22'h0, VEC_TIMER}, {22'h0, last_vec});
		rdchk("status", ADDR_STATUS, 32'h70);
		wr(ADDR_CMD, (32'h1 << CMD_RETURN) | (32'h1 << CMD_HOST_OFF));
		rdchk("status", ADDR_STATUS, 32'h10);
		// Event counting keeps the preset and counts falling edges.
		wr(ADDR_COUNT, 32'h10);
		wr(ADDR_CMD, 32'h1 << CMD_START_EVT);
		rdchk("count", ADDR_COUNT, 32'h10);
		for (int k = 0; k < 3; k++) begin
			event_pin <= 1'h1;
			repeat (45) @(posedge clock);
			event_pin <= 1'h0;
			repeat (45) @(posedge clock);
		end
		rdchk("events", ADDR_COUNT, 32'h13);
		// A timer tick may land before the sample, hence two values.
		wr(ADDR_CMD, 32'h1 << CMD_START_TMR);
		rdchk("status", ADDR_STATUS, 32'h11);
		rd(ADDR_COUNT);
		chk("switch", 32'h1, {31'h0, (q === 32'h13 || q === 32'h14)});
		wr(ADDR_CMD, 32'h1 << CMD_IRQ_OFF);
		rdchk("irq_off_cmd", ADDR_STATUS, 32'h1);
		give_verdict();
	end
endmodule
